// ### rtl/lic_top.sv
// Purpose: Local interrupt controller with serial bus, error register and bus arbitration.
// Assumes: APB slave on pclk; serial bus clock sampled and edge detected on pclk.
// Notes: Zero-wait APB; read data and slave error are registered in the setup cycle.
// Operation
// - Remote-read status reads 10 after a good reply, 00 after a checksum error.
// - Remote-read reply data occupies serial bus cycles 21 to 36.
// - Software read of the error register clears it afterwards unless a backoff comes before the clear lands.
// - Clear lands three clocks later; errors posted meanwhile are kept.
// - Writes to the error register leave its bits unchanged.
// - Priority is the upper four bits of the eight-bit vector.
// - A vector being serviced has its in-service bit set.
// - Local and serial interrupts arriving together are both kept.
// - A badly received message flags a checksum error and is retransmitted unless a remote-read command is already pending.
// - Framing stays synchronised after a bad reply followed by other messages.
// - Parity error pulses when data and byte parity disagree.
// - Internal register reads under hold give no spurious parity error.
// - Parity error never drives while the check enable is high.
// - After backoff only one processor owns the bus.
// - Internal read pipelined behind an outstanding cycle never hangs under hold.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lic_defs.svh"
module lic_top #(
  parameter bit PRIMARY = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic interrupt_bus_clock,
  input wire logic intr_bus_data_in,
  output logic intr_bus_data_out,
  output logic intr_bus_data_oe,
  input wire logic local_irq_valid,
  input wire lic_pkg::lic_vec_t local_irq_vector,
  output logic int_req,
  output lic_pkg::lic_vec_t int_vector,
  input wire logic int_ack,
  input wire logic [31:0] data_lines,
  input wire logic [3:0] byte_parity_lines,
  input wire logic parity_check_enable_n,
  output logic parity_error_out,
  input wire logic hold_req,
  output logic bus_hold_ack,
  input wire logic bus_backoff_n,
  input wire logic address_strobe_n,
  input wire logic burst_ready_n,
  input wire logic want_bus,
  output logic private_bus_request_n,
  input wire logic peer_bus_request_n,
  output logic bus_grant_out,
  input wire logic bus_grant_in,
  output logic bus_owner
);
  import lic_pkg::*;

  function automatic logic [1:0] msg_sum(input logic [`LIC_MSG_LEN-1:0] m);
    logic [1:0] s;
    s = 2'h0;
    for (int i = 1; i < `LIC_CS_LSB; i++)
      s = s + {1'b0, m[i]};
    return s;
  endfunction

  function automatic logic [`LIC_MSG_LEN-1:0] build_msg(input lic_msg_t t, input lic_vec_t v,
                                                        input logic [15:0] d);
    logic [`LIC_MSG_LEN-1:0] m;
    m = '0;
    m[`LIC_TYPE_LSB +: 2] = t;
    m[`LIC_VEC_LSB +: 8] = v;
    m[`LIC_DATA_MSB:`LIC_DATA_LSB] = d;
    m[`LIC_CS_LSB +: 2] = msg_sum(m);
    return m;
  endfunction

  function automatic lic_top_t top_bit(input logic [255:0] v);
    lic_top_t t;
    t = '{found: 1'b0, vec: 8'h00};
    for (int i = 0; i < 256; i++)
      if (v[i])
      begin
        t.found = 1'b1;
        t.vec = i[7:0];
      end
    return t;
  endfunction

  logic [1:0] bus_sync;
  logic clk_d;
  logic [5:0] rx_cnt;
  logic [`LIC_MSG_LEN-1:0] rx_msg;
  logic rx_done;
  logic rx_own;
  logic [`LIC_MSG_LEN-1:0] tx_msg;
  logic [5:0] tx_idx;
  logic tx_busy;
  logic tx_pend;
  logic [31:0] icr;
  logic [15:0] rr_data;
  logic [`LIC_ERR_W-1:0] err;
  logic [`LIC_ERR_W-1:0] err_snap;
  logic [1:0] clr_cnt;
  logic [255:0] pending;
  logic [255:0] in_service;
  logic [1:0] outstanding;
  lic_arb_t arb;

  wire bclk = bus_sync[1];
  wire bdat = bus_sync[0];
  wire b_rise = bclk && !clk_d;
  wire b_fall = !bclk && clk_d;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_done = access && pwrite;
  wire rd_done = access && !pwrite;
  wire sel_icr = paddr == `LIC_ICR_OFS;
  wire sel_rrd = paddr == `LIC_RRD_OFS;
  wire sel_err = paddr == `LIC_ERR_OFS;
  wire sel_eoi = paddr == `LIC_EOI_OFS;
  wire sel_sts = paddr == `LIC_STS_OFS;
  wire mapped = sel_icr || sel_rrd || sel_err || sel_eoi || sel_sts;
  wire rx_last = b_rise && (rx_cnt == 6'(`LIC_MSG_LEN - 1));
  wire rx_start = b_rise && (rx_cnt == 6'h0) && !bdat;
  wire lic_msg_t rx_type = lic_msg_t'(rx_msg[`LIC_TYPE_LSB +: 2]);
  wire lic_vec_t rx_vec = rx_msg[`LIC_VEC_LSB +: 8];
  wire rx_take = rx_done && !rx_own;
  wire rx_cs_ok = rx_msg[`LIC_CS_LSB +: 2] == msg_sum(rx_msg);
  wire rx_bad = rx_take && !rx_cs_ok;
  wire rx_good = rx_take && rx_cs_ok;
  wire icr_wr = wr_done && sel_icr;
  wire lic_vec_t icr_vec = pwdata[7:0];
  wire rr_req = icr_wr && (pwdata[`LIC_MODE_MSB:`LIC_MODE_LSB] == `LIC_MODE_RR);
  wire rr_send = rr_req && !tx_pend && !tx_busy && !rx_bad;
  wire tx_start = b_fall && tx_pend && !tx_busy && (rx_cnt == 6'h0);
  wire tx_end = b_fall && tx_busy && (tx_idx == 6'(`LIC_MSG_LEN - 1));
  wire clr_now = clr_cnt == 2'd1;
  wire lic_top_t hp = top_bit(pending);
  wire lic_top_t hs = top_bit(in_service);
  wire deliver = hp.found && (!hs.found || hp.vec[7:4] > hs.vec[7:4]);
  wire eoi_wr = wr_done && sel_eoi;
  wire internal_rd = psel && !pwrite;
  wire can_hand = (outstanding == 2'h0) && !bus_hold_ack && bus_backoff_n;
  logic [`LIC_ERR_W-1:0] err_set;
  logic [255:0] pend_set;
  logic [255:0] pend_clr;
  logic [255:0] isr_set;
  logic [255:0] isr_clr;
  logic [31:0] rd_mux;

  lic_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({interrupt_bus_clock, intr_bus_data_in}),
    .dout(bus_sync)
  );

  lic_parity_chk u_par (
    .pclk(pclk),
    .presetn(presetn),
    .data_lines(data_lines),
    .byte_parity_lines(byte_parity_lines),
    .burst_ready_n(burst_ready_n),
    .parity_check_enable_n(parity_check_enable_n),
    .suppress(internal_rd),
    .parity_error_out(parity_error_out)
  );

  assign pready = 1'b1;
  assign intr_bus_data_out = 1'b0;
  assign intr_bus_data_oe = tx_busy && !tx_msg[tx_idx];
  assign private_bus_request_n = !(arb == ARB_WAIT);
  assign bus_owner = arb == ARB_OWN;

  always_comb
  begin
    err_set = '0;
    err_set[`LIC_ERR_RX_CS] = rx_bad;
    err_set[`LIC_ERR_RX_VEC] = rx_good && (rx_type == MSG_INT) && (rx_vec < `LIC_MIN_VEC);
    err_set[`LIC_ERR_TX_VEC] = rr_req && (icr_vec < `LIC_MIN_VEC);
    err_set[`LIC_ERR_PAR] = parity_error_out;
    pend_set = '0;
    if (rx_good && (rx_type == MSG_INT) && (rx_vec >= `LIC_MIN_VEC))
      pend_set[rx_vec] = 1'b1;
    if (local_irq_valid && (local_irq_vector >= `LIC_MIN_VEC))
      pend_set[local_irq_vector] = 1'b1;
    pend_clr = '0;
    isr_set = '0;
    if (int_ack && int_req)
    begin
      pend_clr[int_vector] = 1'b1;
      isr_set[int_vector] = 1'b1;
    end
    isr_clr = '0;
    if (eoi_wr && hs.found)
      isr_clr[hs.vec] = 1'b1;
    rd_mux = 32'h0;
    if (sel_icr)
      rd_mux = icr;
    if (sel_rrd)
      rd_mux = {16'h0, rr_data};
    if (sel_err)
      rd_mux = {{(32-`LIC_ERR_W){1'b0}}, err};
    if (sel_sts)
      rd_mux = {20'h0, tx_busy, bus_owner, int_req, hs.found, hs.vec};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_d <= 1'b1;
    else
      clk_d <= bclk;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_cnt <= 6'h0;
    else if (rx_start)
      rx_cnt <= 6'h1;
    else if (rx_last)
      rx_cnt <= 6'h0;
    else if (b_rise && (rx_cnt != 6'h0))
      rx_cnt <= rx_cnt + 6'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_msg <= '0;
    else if (b_rise && (rx_cnt != 6'h0))
      rx_msg[rx_cnt] <= bdat;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_done <= 1'b0;
      rx_own <= 1'b0;
    end
    else
    begin
      rx_done <= rx_last;
      if (rx_start)
        rx_own <= tx_busy || tx_start;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_msg <= '1;
    else if (rx_bad && !tx_pend && !tx_busy)
      tx_msg <= rx_msg;
    else if (rr_send)
      tx_msg <= build_msg(MSG_CMD, icr_vec, 16'h0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_pend <= 1'b0;
    else if ((rx_bad && !tx_busy) || rr_send)
      tx_pend <= 1'b1;
    else if (tx_start)
      tx_pend <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_busy <= 1'b0;
      tx_idx <= 6'h0;
    end
    else if (tx_start)
    begin
      tx_busy <= 1'b1;
      tx_idx <= 6'h0;
    end
    else if (tx_end)
      tx_busy <= 1'b0;
    else if (b_fall && tx_busy)
      tx_idx <= tx_idx + 6'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      icr <= `LIC_ICR_RST;
    else
    begin
      if (icr_wr)
        icr[31:`LIC_RR_MSB+1] <= pwdata[31:`LIC_RR_MSB+1];
      if (icr_wr)
        icr[`LIC_RR_LSB-1:0] <= pwdata[`LIC_RR_LSB-1:0];
      if (rx_good && (rx_type == MSG_RR_REPLY))
        icr[`LIC_RR_MSB:`LIC_RR_LSB] <= `LIC_RR_VALID;
      else if (rx_bad && (rx_type == MSG_RR_REPLY))
        icr[`LIC_RR_MSB:`LIC_RR_LSB] <= `LIC_RR_INVALID;
      else if (rr_send)
        icr[`LIC_RR_MSB:`LIC_RR_LSB] <= `LIC_RR_PEND;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rr_data <= 16'h0;
    else if (rx_good && (rx_type == MSG_RR_REPLY))
      rr_data <= rx_msg[`LIC_DATA_MSB:`LIC_DATA_LSB];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_snap <= '0;
    else if (setup && sel_err && !pwrite)
      err_snap <= err;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_cnt <= 2'd0;
    else if (!bus_backoff_n)
      clr_cnt <= 2'd0;
    else if (rd_done && sel_err)
      clr_cnt <= `LIC_CLR_DELAY;
    else if (clr_cnt != 2'd0)
      clr_cnt <= clr_cnt - 2'd1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err <= '0;
    else
      err <= (err & ~(clr_now ? err_snap : '0)) | err_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending <= '0;
      in_service <= '0;
    end
    else
    begin
      pending <= (pending & ~pend_clr) | pend_set;
      in_service <= (in_service & ~isr_clr) | isr_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_req <= 1'b0;
      int_vector <= 8'h00;
    end
    else if (!(int_req && int_ack))
    begin
      int_req <= deliver;
      int_vector <= hp.vec;
    end
    else
      int_req <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      outstanding <= 2'h0;
    else if (!bus_backoff_n)
      outstanding <= 2'h0;
    else if (!address_strobe_n && burst_ready_n && (outstanding != 2'h3))
      outstanding <= outstanding + 2'h1;
    else if (address_strobe_n && !burst_ready_n && (outstanding != 2'h0))
      outstanding <= outstanding - 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_hold_ack <= 1'b0;
    else
      bus_hold_ack <= hold_req && (outstanding == 2'h0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arb <= PRIMARY ? ARB_OWN : ARB_IDLE;
      bus_grant_out <= 1'b0;
    end
    else
    begin
      bus_grant_out <= 1'b0;
      unique case (arb)
        ARB_OWN:
          if (!peer_bus_request_n && can_hand)
          begin
            arb <= ARB_IDLE;
            bus_grant_out <= 1'b1;
          end
        ARB_IDLE:
          if (want_bus)
            arb <= ARB_WAIT;
        ARB_WAIT:
          if (bus_grant_in)
            arb <= ARB_OWN;
        default:
          arb <= ARB_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rtl/lic_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the controller.
// Assumes: Byte addresses on an APB bus with 32-bit data.
// Notes: Serial message cycles are numbered from 1; bit index is cycle minus one.
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH
`define LIC_ICR_OFS 8'h00
`define LIC_RRD_OFS 8'h04
`define LIC_ERR_OFS 8'h08
`define LIC_EOI_OFS 8'h0c
`define LIC_STS_OFS 8'h10
`define LIC_ICR_RST 32'h0000_0000
`define LIC_RR_LSB 16
`define LIC_RR_MSB 17
`define LIC_RR_INVALID 2'b00
`define LIC_RR_PEND 2'b01
`define LIC_RR_VALID 2'b10
`define LIC_MODE_LSB 8
`define LIC_MODE_MSB 10
`define LIC_MODE_RR 3'h3
`define LIC_MSG_LEN 38
`define LIC_TYPE_LSB 1
`define LIC_VEC_LSB 3
`define LIC_DATA_LSB 20
`define LIC_DATA_MSB 35
`define LIC_CS_LSB 36
`define LIC_ERR_RX_CS 0
`define LIC_ERR_RX_VEC 1
`define LIC_ERR_TX_VEC 2
`define LIC_ERR_PAR 3
`define LIC_ERR_W 4
`define LIC_CLR_DELAY 2'd3
`define LIC_MIN_VEC 8'h10
`endif

// ### rtl/lic_pkg.sv
// Purpose: Types shared by the local interrupt controller files.
// Assumes: Nothing beyond the defines header.
// Notes: Message kinds follow the order of the two type bits on the serial bus.
package lic_pkg;
  typedef logic [7:0] lic_vec_t;
  typedef enum logic [1:0] {MSG_INT, MSG_EOI, MSG_RR_REPLY, MSG_CMD} lic_msg_t;
  typedef struct packed {
    logic found;
    lic_vec_t vec;
  } lic_top_t;
  typedef enum logic [1:0] {ARB_OWN, ARB_IDLE, ARB_WAIT} lic_arb_t;
endpackage

// ### rtl/lic_sync2.sv
// Purpose: Two flip-flop synchroniser for signals from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module lic_sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '1;
      dout <= '1;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/lic_parity_chk.sv
// Purpose: Checks the data lines against their byte parity on each burst ready while the check is enabled and not suppressed.
// Assumes: Even parity per byte, inputs on the processor clock.
// Notes: The error output is a one-clock pulse.
`timescale 1ns/1ps
`default_nettype none
module lic_parity_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] data_lines,
  input wire logic [3:0] byte_parity_lines,
  input wire logic burst_ready_n,
  input wire logic parity_check_enable_n,
  input wire logic suppress,
  output logic parity_error_out
);
  logic [3:0] lane_bad;
  logic check_now;

  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign lane_bad[b] = ^{data_lines[8*b+7 -: 8], byte_parity_lines[b]};
  end
  assign check_now = !burst_ready_n && !parity_check_enable_n && !suppress;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      parity_error_out <= 1'b0;
    else
      parity_error_out <= check_now && (lane_bad != 4'h0);
  end
endmodule
`default_nettype wire

// ### dv/lic_properties.sv
// Purpose: Port checks of parity, hold, arbitration and interrupt hand-off.
// Assumes: One clock domain, reset active low.
// Notes: Bound into every lic_top instance.
`timescale 1ns/1ps
`default_nettype none
module lic_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [31:0] data_lines,
  input wire logic [3:0] byte_parity_lines,
  input wire logic parity_check_enable_n,
  input wire logic burst_ready_n,
  input wire logic parity_error_out,
  input wire logic hold_req,
  input wire logic bus_hold_ack,
  input wire logic bus_backoff_n,
  input wire logic peer_bus_request_n,
  input wire logic bus_grant_in,
  input wire logic bus_grant_out,
  input wire logic bus_owner,
  input wire logic private_bus_request_n,
  input wire logic int_req,
  input wire logic int_ack
);
  wire par_bad = ^{data_lines[7:0], byte_parity_lines[0]} | ^{data_lines[15:8],
    byte_parity_lines[1]} | ^{data_lines[23:16], byte_parity_lines[2]} |
    ^{data_lines[31:24], byte_parity_lines[3]};
  wire par_hit = !burst_ready_n && !parity_check_enable_n && par_bad;
  wire grant_ok = bus_owner && !peer_bus_request_n && !bus_hold_ack && bus_backoff_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_parity_fires: assert property (par_hit && !(psel && !pwrite) |=> parity_error_out)
    else $error("parity mismatch gave no pulse");
  a_parity_cause: assert property (parity_error_out |-> $past(par_hit))
    else $error("parity pulse without enabled mismatch");
  a_read_quiet: assert property (psel && !pwrite |=> !parity_error_out)
    else $error("parity pulse during register read");
  a_hold_cause: assert property (bus_hold_ack |-> $past(hold_req))
    else $error("hold ack without hold request");
  a_owner_quiet: assert property (bus_owner |-> private_bus_request_n)
    else $error("owner requests the bus");
  a_handoff_pulse: assert property ($fell(bus_owner) |-> bus_grant_out)
    else $error("ownership dropped without grant");
  a_grant_cause: assert property (bus_grant_out |-> $past(grant_ok))
    else $error("grant given while not free to hand off");
  a_owner_taken: assert property ($rose(bus_owner) |-> $past(bus_grant_in) ||
    $past(bus_grant_in, 2))
    else $error("ownership taken without grant");
  a_ack_clears: assert property (int_ack && int_req |-> ##[1:2] !int_req)
    else $error("request stays after acknowledge");
endmodule
bind lic_top lic_properties chk_u (.pclk, .presetn, .psel, .pwrite, .data_lines,
  .byte_parity_lines, .parity_check_enable_n, .burst_ready_n, .parity_error_out, .hold_req,
  .bus_hold_ack, .bus_backoff_n, .peer_bus_request_n, .bus_grant_in, .bus_grant_out,
  .bus_owner, .private_bus_request_n, .int_req, .int_ack);
`default_nettype wire

// ### dv/lic_peer.sv
// Purpose: Peer controller on the serial interrupt bus.
// Assumes: The wire has a pull-up; a high pull output pulls it low.
// Notes: The bus clock runs only during frames and requested idle stretches.
`timescale 1ns/1ps
`default_nettype none
module lic_peer (
  output var logic interrupt_bus_clock,
  output var logic peer_pull
);
  initial
  begin
    interrupt_bus_clock = 1'b1;
    peer_pull = 1'b0;
  end
  task automatic tick(input logic pull);
    #40 interrupt_bus_clock = 1'b0;
    peer_pull = pull;
    #40 interrupt_bus_clock = 1'b1;
  endtask
  task automatic idle(input int n);
    repeat (n) tick(1'b0);
  endtask
  task automatic send(input logic [1:0] kind, input logic [7:0] vec, input logic [15:0] data,
    input logic bad);
    logic [37:0] m;
    logic [1:0] ones;
    m = {2'b00, data, 9'h000, vec, kind, 1'b0};
    ones = 2'b00;
    for (int i = 1; i < 36; i++)
      ones = ones + {1'b0, m[i]};
    m[37:36] = ones ^ {1'b0, bad};
    for (int i = 0; i < 38; i++)
      tick(!m[i]);
    #40 peer_pull = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Purpose: Self-checking bench of the local interrupt controller.
// Assumes: Zero-wait APB, peer model on the serial bus.
// Notes: Ordinary register accesses run from a table.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lic_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} lic_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, local_irq_valid = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, data_lines = 32'h0, prdata, rd;
  logic [3:0] byte_parity_lines = 4'h0;
  logic int_ack = 0, parity_check_enable_n = 1, hold_req = 0, bus_backoff_n = 1;
  logic address_strobe_n = 1, burst_ready_n = 1, want_bus = 0, peer_bus_request_n = 1;
  logic bus_grant_in = 0, pready, pslverr, interrupt_bus_clock, intr_bus_data_in, er;
  logic intr_bus_data_out, intr_bus_data_oe, int_req, parity_error_out, bus_hold_ack;
  logic private_bus_request_n, bus_grant_out, bus_owner, peer_pull;
  lic_vec_t local_irq_vector = 8'h00, int_vector, v0, v1, v2;
  int err_total = 0, n_tests = 0, cyc = 0, par_cnt = 0, oe_cnt = 0, n0;
  lic_row_t rows [9] = '{{1'b1, 8'h00, 32'h20, 32'h0, 1'b0}, {1'b0, 8'h00, 32'h0, 32'h20, 1'b0},
    {1'b1, 8'h08, 32'hf, 32'h0, 1'b0}, {1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    {1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h10, 32'h0, 32'h400, 1'b0},
    {1'b0, 8'h20, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h04, 32'hffff, 32'h0, 1'b0},
    {1'b0, 8'h04, 32'h0, 32'h0, 1'b0}};
  assign intr_bus_data_in = !(intr_bus_data_oe || peer_pull);
  lic_top #(.PRIMARY(1'b1)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .interrupt_bus_clock, .intr_bus_data_in, .intr_bus_data_out,
    .intr_bus_data_oe, .local_irq_valid, .local_irq_vector, .int_req, .int_vector, .int_ack,
    .data_lines, .byte_parity_lines, .parity_check_enable_n, .parity_error_out, .hold_req,
    .bus_hold_ack, .bus_backoff_n, .address_strobe_n, .burst_ready_n, .want_bus,
    .private_bus_request_n, .peer_bus_request_n, .bus_grant_out, .bus_grant_in, .bus_owner);
  lic_peer peer_u (.interrupt_bus_clock, .peer_pull);
  always #5 pclk = ~pclk;
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    par_cnt <= par_cnt + parity_error_out;
    oe_cnt <= oe_cnt + intr_bus_data_oe;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] q, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, q, what);
  endtask
  task automatic par(input logic en_n);
    @(posedge pclk);
    data_lines <= 32'h1;
    parity_check_enable_n <= en_n;
    burst_ready_n <= 1'b0;
    @(posedge pclk);
    burst_ready_n <= 1'b1;
    parity_check_enable_n <= 1'b1;
  endtask
  task automatic irq(input lic_vec_t v);
    @(posedge pclk);
    local_irq_valid <= 1'b1;
    local_irq_vector <= v;
    @(posedge pclk);
    local_irq_valid <= 1'b0;
  endtask
  task automatic take_int(output lic_vec_t v);
    @(negedge pclk);
    for (int k = 0; k < 60 && int_req !== 1'b1; k++)
      @(negedge pclk);
    v = int_vector;
    @(posedge pclk);
    int_ack <= 1'b1;
    @(posedge pclk);
    int_ack <= 1'b0;
  endtask
  initial
  begin
    repeat (11) @(posedge pclk);
    @(negedge pclk);
    check({23'h0, bus_grant_out, intr_bus_data_out, pslverr, int_req, bus_hold_ack,
      private_bus_request_n, bus_owner, intr_bus_data_oe, parity_error_out}, 32'hc,
      "reset outputs");
    @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(rd, rows[i].q, "row data");
      check({31'h0, er}, {31'h0, rows[i].e}, "row error");
    end
    $display("register table done");
    apb(1'b1, 8'h00, 32'h320);
    peer_u.idle(45);
    peer_u.send(2'd2, 8'h20, 16'h1234, 1'b0);
    rreg(8'h00, 32'h0002_0320, "good reply status");
    rreg(8'h04, 32'h1234, "reply data");
    apb(1'b1, 8'h00, 32'h320);
    peer_u.idle(45);
    peer_u.send(2'd2, 8'h20, 16'h0600, 1'b1);
    rreg(8'h00, 32'h320, "bad reply status");
    n0 = oe_cnt;
    peer_u.idle(45);
    check({31'h0, oe_cnt > n0}, 32'h1, "resend");
    $display("remote read done");
    apb(1'b1, 8'h08, 32'h0);
    rreg(8'h08, 32'h1, "error after write");
    n0 = par_cnt;
    par(1'b0);
    repeat (4) @(posedge pclk);
    rreg(8'h08, 32'h8, "error during clear");
    repeat (4) @(posedge pclk);
    rreg(8'h08, 32'h0, "error cleared");
    check({31'h0, par_cnt == n0 + 1}, 32'h1, "parity pulse");
    par(1'b1);
    repeat (3) @(posedge pclk);
    check({31'h0, par_cnt == n0 + 1}, 32'h1, "parity off");
    fork
      rreg(8'h10, 32'h400, "status under hold");
      begin
        repeat (2) @(posedge pclk);
        hold_req <= 1'b1;
        parity_check_enable_n <= 1'b0;
        burst_ready_n <= 1'b0;
        @(posedge pclk);
        hold_req <= 1'b0;
        parity_check_enable_n <= 1'b1;
        burst_ready_n <= 1'b1;
      end
    join
    repeat (2) @(posedge pclk);
    check({31'h0, par_cnt == n0 + 1}, 32'h1, "no pulse in read");
    $display("error register done");
    @(posedge pclk);
    address_strobe_n <= 1'b0;
    hold_req <= 1'b1;
    @(posedge pclk);
    address_strobe_n <= 1'b1;
    repeat (4) @(negedge pclk);
    check({31'h0, bus_hold_ack}, 32'h0, "no ack in open cycle");
    par(1'b1);
    repeat (3) @(negedge pclk);
    check({31'h0, bus_hold_ack}, 32'h1, "ack after ready");
    @(posedge pclk);
    hold_req <= 1'b0;
    peer_bus_request_n <= 1'b0;
    repeat (5) @(negedge pclk);
    check({31'h0, bus_owner}, 32'h0, "handed off");
    @(posedge pclk);
    peer_bus_request_n <= 1'b1;
    want_bus <= 1'b1;
    repeat (3) @(negedge pclk);
    check({30'h0, bus_owner, private_bus_request_n}, 32'h0, "requesting");
    @(posedge pclk);
    bus_grant_in <= 1'b1;
    @(posedge pclk);
    bus_grant_in <= 1'b0;
    want_bus <= 1'b0;
    repeat (3) @(negedge pclk);
    check({30'h0, bus_owner, private_bus_request_n}, 32'h3, "owner again");
    $display("arbitration done");
    irq(8'h45);
    take_int(v0);
    check({24'h0, v0}, 32'h45, "local vector");
    repeat (2) @(posedge pclk);
    rreg(8'h10, 32'h545, "in service");
    peer_u.send(2'd0, 8'h47, 16'h0, 1'b0);
    irq(8'h48);
    peer_u.idle(2);
    @(negedge pclk);
    check({31'h0, int_req}, 32'h0, "equal priority waits");
    apb(1'b1, 8'h0c, 32'h0);
    take_int(v1);
    apb(1'b1, 8'h0c, 32'h0);
    take_int(v2);
    apb(1'b1, 8'h0c, 32'h0);
    check({16'h0, (v1 < v2) ? {v1, v2} : {v2, v1}}, 32'h4748, "both kept");
    $display("interrupts done");
    final_report();
  end
endmodule
`default_nettype wire
